//--- dsac_conv_model.sv
// behavioural converter core answering start pulses
`timescale 1ns/10ps
`default_nettype none
module dsac_conv_model #(
  parameter int          LAT = 100,     // 1 us per conversion at 100 MHz
  parameter logic [15:0] VAL = 16'h1234 // result returned
) (
  input  wire logic        clk_i,
  input  wire logic        rstn_i,
  input  wire logic        start_i,
  output logic             done_o,
  output logic [15:0]      data_o
);
  int cnt;  // cycles left in conversion
  // data toggles outside done so stale values never look valid
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      cnt    <= 0;
      done_o <= 1'b0;
      data_o <= ~VAL;
    end else begin
      done_o <= (cnt == 1);
      data_o <= (cnt == 1) ? VAL : ~data_o;
      if (start_i) cnt <= LAT;
      else if (cnt != 0) cnt <= cnt - 1;
    end
  end
endmodule : dsac_conv_model
`default_nettype wire

//--- dsac_fifo.sv
// result buffer with registered read data and valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module dsac_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             CLK_I,
  input  wire logic             RSTN_I,
  input  wire logic [WIDTH-1:0] in_data_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  output logic      [WIDTH-1:0] out_data_o,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];            // storage behind output stage
  logic [PW-1:0]    wr_ptr_reg;             // next write slot
  logic [PW-1:0]    rd_ptr_reg;             // next read slot
  logic [CW-1:0]    count_reg;              // words in storage
  logic             push;                   // accepted input word
  logic             load_out;               // output stage may take a word
  logic             take_mem;               // output stage reads storage
  logic             bypass;                 // input goes straight to output
  logic             store;                  // input goes to storage

  // storage full means real back-pressure toward the converters
  assign in_ready_o = (count_reg != CW'(DEPTH));
  assign push       = in_valid_i && in_ready_o;
  assign load_out   = !out_valid_o || out_ready_i;
  assign take_mem   = load_out && (count_reg != '0);
  assign bypass     = load_out && (count_reg == '0) && push;
  assign store      = push && !bypass;

  // output stage, read data always from a register
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end else if (load_out) begin
      if (take_mem) begin
        out_data_o  <= mem[rd_ptr_reg];
        out_valid_o <= 1'b1;
      end else if (bypass) begin
        out_data_o  <= in_data_i;
        out_valid_o <= 1'b1;
      end else begin
        out_valid_o <= 1'b0;
      end
    end
  end

  // storage array, no reset needed
  always_ff @(posedge CLK_I) begin
    if (store) begin
      mem[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and fill level; depth is a power of two so pointers wrap
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (store) begin
        wr_ptr_reg <= wr_ptr_reg + PW'(1);
      end
      if (take_mem) begin
        rd_ptr_reg <= rd_ptr_reg + PW'(1);
      end
      count_reg <= count_reg + CW'(store) - CW'(take_mem);
    end
  end

endmodule : dsac_fifo
`default_nettype wire

//--- dsac_pkg.sv
// constants, types and register map of the dual converter control block
// What this block does
// R01: start on software, timer2, timer3 or external trigger
// R02: converters run independently or start together
// R03: single-ended each, or paired differential measurement
// R04: completion sets status bit, optional interrupt
// R05: capture full 16-bit result at conversion end
// R06: transfer engine writes results to chosen memory
// R07: first converter window compare, inside or outside
// R08: background monitoring interrupts only on qualifying results
// R09: shutdown control stops converters to save power
// R10: triggers stay below 1 Msps per converter
// R11: busy converter ignores triggers; status stays until cleared
package dsac_pkg;

  localparam int DSAC_DATA_W  = 16;         // converter result width
  localparam int DSAC_ADDR_W  = 6;          // axi byte address width
  localparam int DSAC_FIFO_D  = 8;          // transfer buffer depth

  // register byte offsets
  localparam logic [5:0] OFS_CTRL   = 6'h00;
  localparam logic [5:0] OFS_CMD    = 6'h04;
  localparam logic [5:0] OFS_STATUS = 6'h08;
  localparam logic [5:0] OFS_RES0   = 6'h0c;
  localparam logic [5:0] OFS_RES1   = 6'h10;
  localparam logic [5:0] OFS_WINLO  = 6'h14;
  localparam logic [5:0] OFS_WINHI  = 6'h18;
  localparam logic [5:0] OFS_DMABASE = 6'h1c;

  // status / command bit positions
  localparam int ST_DONE0 = 0;
  localparam int ST_DONE1 = 1;
  localparam int ST_WIN   = 2;
  localparam int ST_BUSY0 = 3;
  localparam int ST_BUSY1 = 4;
  localparam int CMD_GO0  = 0;
  localparam int CMD_GO1  = 1;

  // reset values
  localparam logic [11:0] CTRL_RST  = 12'h001;  // shut down after reset
  localparam logic [15:0] WINLO_RST = 16'h0000;
  localparam logic [15:0] WINHI_RST = 16'hffff;
  localparam logic [15:0] BASE_RST  = 16'h0000;
  localparam logic [15:0] ADDR_STEP = 16'h0002;  // bytes per stored result

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // conversion trigger source
  typedef enum logic [1:0] {TRIG_SW, TRIG_T2, TRIG_T3, TRIG_EXT} dsac_trig_t;

  // control register layout, lsb first from shutdown
  typedef struct packed {
    dsac_trig_t trig1;
    dsac_trig_t trig0;
    logic       win_irq_en;
    logic       done_irq_en;
    logic       win_inside;
    logic       dma_ext;
    logic       dma_en;
    logic       diff;
    logic       sync;
    logic       shutdown;
  } dsac_ctrl_t;

  // one memory write of the transfer engine
  typedef struct packed {
    logic        ext;
    logic [15:0] addr;
    logic [15:0] data;
  } dsac_mem_wr_t;

endpackage : dsac_pkg

//--- dsac_top.sv
// trigger, capture, window compare and transfer control of two converters
`timescale 1ns/10ps
`default_nettype none
module dsac_top #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                         CLK_I,
  input  wire logic                         RSTN_I,
  // axi4-lite slave
  input  wire logic [dsac_pkg::DSAC_ADDR_W-1:0] S_AXI_AWADDR_I,
  input  wire logic                         S_AXI_AWVALID_I,
  output logic                              S_AXI_AWREADY_O,
  input  wire logic [31:0]                  S_AXI_WDATA_I,
  input  wire logic [3:0]                   S_AXI_WSTRB_I,
  input  wire logic                         S_AXI_WVALID_I,
  output logic                              S_AXI_WREADY_O,
  output logic [1:0]                        S_AXI_BRESP_O,
  output logic                              S_AXI_BVALID_O,
  input  wire logic                         S_AXI_BREADY_I,
  input  wire logic [dsac_pkg::DSAC_ADDR_W-1:0] S_AXI_ARADDR_I,
  input  wire logic                         S_AXI_ARVALID_I,
  output logic                              S_AXI_ARREADY_O,
  output logic [31:0]                       S_AXI_RDATA_O,
  output logic [1:0]                        S_AXI_RRESP_O,
  output logic                              S_AXI_RVALID_O,
  input  wire logic                         S_AXI_RREADY_I,
  // triggers
  input  wire logic                         TMR2_OVF_I,
  input  wire logic                         TMR3_OVF_I,
  input  wire logic                         EXT_START_I,
  // converter cores
  output logic                              CONV0_START_O,
  output logic                              CONV1_START_O,
  input  wire logic                         CONV0_DONE_I,
  input  wire logic                         CONV1_DONE_I,
  input  wire logic [dsac_pkg::DSAC_DATA_W-1:0] CONV0_DATA_I,
  input  wire logic [dsac_pkg::DSAC_DATA_W-1:0] CONV1_DATA_I,
  output logic                              DIFF_O,
  output logic                              SHDN_O,
  // interrupt requests
  output logic                              CONV_IRQ_O,
  output logic                              WIN_IRQ_O,
  // memory write port of the transfer engine
  output dsac_pkg::dsac_mem_wr_t            MEM_WR_O,
  output logic                              MEM_REQ_O,
  input  wire logic                         MEM_ACK_I
);
  import dsac_pkg::*;

  typedef enum {DMA_IDLE, DMA_WRITE} dsac_dma_st_t;

  // software-visible state
  dsac_ctrl_t        ctrl_reg;               // control bits
  logic [15:0]       winlo_reg;              // window lower bound
  logic [15:0]       winhi_reg;              // window upper bound
  logic [15:0]       base_reg;               // transfer base address
  logic [15:0]       res0_reg;               // first converter result
  logic [15:0]       res1_reg;               // second converter result
  logic [1:0]        done_reg;               // completion flags
  logic              win_reg;                // window hit flag
  logic              busy0_reg;              // first converter running
  logic              busy1_reg;              // second converter running
  // axi slave state
  logic              aw_full_reg;
  logic              w_full_reg;
  logic [5:0]        awaddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              wr_en;                  // register write this cycle
  logic [31:0]       old_word;               // current value at write address
  logic [31:0]       wr_word;                // value after byte strobes
  // trigger path
  logic              ext_s1_reg;             // synchroniser stage one
  logic              ext_s2_reg;             // synchroniser stage two
  logic              ext_s3_reg;             // edge history
  logic              ext_edge;
  logic              sw0;
  logic              sw1;
  logic              room;                   // buffer can take a result
  logic              lock;                   // both start together
  logic              go0;
  logic              go1;
  logic              end0;
  logic              end1;
  logic              win_hit;
  // transfer path
  logic              pend1_reg;              // second result awaiting buffer
  logic              fifo_in_valid;
  logic [15:0]       fifo_in_data;
  logic              fifo_in_ready;
  logic [15:0]       fifo_out_data;
  logic              fifo_out_valid;
  logic [15:0]       addr_ptr_reg;
  dsac_dma_st_t      dma_st_reg;

  // merge byte lanes of a write into the old word
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) r[8*b +: 8] = n[8*b +: 8];
    end
    return r;
  endfunction : merge

  // register read decode, shared by read channel and write merge
  function automatic logic [31:0] rd_mux(input logic [5:0] a);
    case (a)
      OFS_CTRL:    rd_mux = {20'h0, ctrl_reg};
      OFS_STATUS:  rd_mux = {27'h0, busy1_reg, busy0_reg, win_reg, done_reg};
      OFS_RES0:    rd_mux = {16'h0, res0_reg};
      OFS_RES1:    rd_mux = {16'h0, res1_reg};
      OFS_WINLO:   rd_mux = {16'h0, winlo_reg};
      OFS_WINHI:   rd_mux = {16'h0, winhi_reg};
      OFS_DMABASE: rd_mux = {16'h0, base_reg};
      default:     rd_mux = 32'h0;
    endcase
  endfunction : rd_mux

  function automatic logic mapped(input logic [5:0] a);
    return (a[1:0] == 2'b00) && (a <= OFS_DMABASE);
  endfunction : mapped

  // selected trigger source fired this cycle
  function automatic logic trig_hit(input dsac_trig_t t, input logic sw);
    case (t)
      TRIG_SW:  trig_hit = sw;
      TRIG_T2:  trig_hit = TMR2_OVF_I;
      TRIG_T3:  trig_hit = TMR3_OVF_I;
      TRIG_EXT: trig_hit = ext_edge;
      default:  trig_hit = 1'b0;
    endcase
  endfunction : trig_hit

  // write address channel
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      aw_full_reg     <= 1'b0;
      awaddr_reg      <= '0;
      S_AXI_AWREADY_O <= 1'b1;
    end else if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
      aw_full_reg     <= 1'b1;
      awaddr_reg      <= S_AXI_AWADDR_I;
      S_AXI_AWREADY_O <= 1'b0;
    end else if (wr_en) begin
      aw_full_reg     <= 1'b0;
    end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
      S_AXI_AWREADY_O <= 1'b1;
    end
  end

  // write data channel
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      w_full_reg     <= 1'b0;
      wdata_reg      <= '0;
      wstrb_reg      <= '0;
      S_AXI_WREADY_O <= 1'b1;
    end else if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
      w_full_reg     <= 1'b1;
      wdata_reg      <= S_AXI_WDATA_I;
      wstrb_reg      <= S_AXI_WSTRB_I;
      S_AXI_WREADY_O <= 1'b0;
    end else if (wr_en) begin
      w_full_reg     <= 1'b0;
    end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
      S_AXI_WREADY_O <= 1'b1;
    end
  end

  // write happens once both halves are held; readies reopen after b
  assign wr_en    = aw_full_reg && w_full_reg && !S_AXI_BVALID_O;
  // comb block, so register edits behind the decode are seen as well
  always_comb begin
    old_word = rd_mux(awaddr_reg);
  end
  assign wr_word  = merge(old_word, wdata_reg, wstrb_reg);

  // write response
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O  <= RESP_OKAY;
    end else if (wr_en) begin
      S_AXI_BVALID_O <= 1'b1;
      S_AXI_BRESP_O  <= mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY_I) begin
      S_AXI_BVALID_O <= 1'b0;
    end
  end

  // read channel, one cycle from address to data
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      S_AXI_ARREADY_O <= 1'b1;
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_RDATA_O   <= '0;
      S_AXI_RRESP_O   <= RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_ARREADY_O <= 1'b0;
      S_AXI_RVALID_O  <= 1'b1;
      S_AXI_RDATA_O   <= rd_mux(S_AXI_ARADDR_I);
      S_AXI_RRESP_O   <= mapped(S_AXI_ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O  <= 1'b0;
      S_AXI_ARREADY_O <= 1'b1;
    end
  end

  // configuration registers
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ctrl_reg  <= dsac_ctrl_t'(CTRL_RST);
      winlo_reg <= WINLO_RST;
      winhi_reg <= WINHI_RST;
      base_reg  <= BASE_RST;
    end else if (wr_en) begin
      case (awaddr_reg)
        OFS_CTRL:    ctrl_reg  <= dsac_ctrl_t'(wr_word[11:0]);  // R09
        OFS_WINLO:   winlo_reg <= wr_word[15:0];
        OFS_WINHI:   winhi_reg <= wr_word[15:0];
        OFS_DMABASE: base_reg  <= wr_word[15:0];
        default:     ;  // other offsets carry no configuration
      endcase
    end
  end

  // external start pin: two flops before the edge detector reads it
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
    end else begin
      ext_s1_reg <= EXT_START_I;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
    end
  end

  assign ext_edge = ext_s2_reg && !ext_s3_reg;
  // software start is a write of one to the command word
  assign sw0      = wr_en && (awaddr_reg == OFS_CMD) && wstrb_reg[0] && wdata_reg[CMD_GO0];
  assign sw1      = wr_en && (awaddr_reg == OFS_CMD) && wstrb_reg[0] && wdata_reg[CMD_GO1];
  // a full buffer holds off new conversions rather than losing results
  assign room     = !ctrl_reg.dma_en || (fifo_in_ready && !pend1_reg);
  assign lock     = ctrl_reg.sync || ctrl_reg.diff;  // R02 R03
  // window test of a raw result against the programmed bounds
  function automatic logic res_in_window(input logic [15:0] d);
    return (d >= winlo_reg) && (d <= winhi_reg);
  endfunction : res_in_window

  // busy converters and shutdown swallow triggers; a comb block so that
  // pins and registers read inside the helper functions wake it up too
  always_comb begin
    go0 = !ctrl_reg.shutdown && room && !busy0_reg && (!lock || !busy1_reg)
          && trig_hit(ctrl_reg.trig0, sw0);  // R01 R09 R11
    go1 = lock ? go0  // R02
               : (!ctrl_reg.shutdown && room && !busy1_reg
                  && trig_hit(ctrl_reg.trig1, sw1));  // R01 R11
    win_hit = (res_in_window(CONV0_DATA_I) == ctrl_reg.win_inside);  // R07
  end
  assign end0 = busy0_reg && CONV0_DONE_I;
  assign end1 = busy1_reg && CONV1_DONE_I;

  // converter start pulses and mode pins
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      CONV0_START_O <= 1'b0;
      CONV1_START_O <= 1'b0;
      DIFF_O        <= 1'b0;
      SHDN_O        <= 1'b1;
    end else begin
      CONV0_START_O <= go0;  // R01
      CONV1_START_O <= go1;  // R02
      DIFF_O        <= ctrl_reg.diff;  // R03
      SHDN_O        <= ctrl_reg.shutdown;  // R09
    end
  end

  // busy tracking; shutdown abandons a conversion in flight
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I || ctrl_reg.shutdown) begin
      busy0_reg <= 1'b0;
      busy1_reg <= 1'b0;
    end else begin
      if (go0) busy0_reg <= 1'b1;
      else if (CONV0_DONE_I) busy0_reg <= 1'b0;
      if (go1) busy1_reg <= 1'b1;
      else if (CONV1_DONE_I) busy1_reg <= 1'b0;
    end
  end

  // result capture at conversion end
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      res0_reg <= '0;
      res1_reg <= '0;
    end else begin
      if (end0) res0_reg <= CONV0_DATA_I;  // R05
      if (end1) res1_reg <= CONV1_DATA_I;  // R05
    end
  end

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      done_reg <= 2'b00;
      win_reg  <= 1'b0;
    end else begin
      if (wr_en && awaddr_reg == OFS_STATUS) begin
        done_reg <= (done_reg & ~wr_word[ST_DONE1:ST_DONE0]) | {end1, end0};  // R04 R11
        win_reg  <= (win_reg & ~wr_word[ST_WIN]) | (end0 && win_hit);  // R07
      end else begin
        done_reg <= done_reg | {end1, end0};  // R04 R11
        win_reg  <= win_reg | (end0 && win_hit);  // R08
      end
    end
  end

  // interrupt lines follow enabled flags
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      CONV_IRQ_O <= 1'b0;
      WIN_IRQ_O  <= 1'b0;
    end else begin
      CONV_IRQ_O <= ctrl_reg.done_irq_en && (|done_reg);  // R04
      WIN_IRQ_O  <= ctrl_reg.win_irq_en && win_reg;  // R07 R08
    end
  end

  // second result waits one cycle, or longer while the buffer is full, when both finish together
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pend1_reg <= 1'b0;
    end else if (end1 && ctrl_reg.dma_en && !ctrl_reg.diff && (end0 || pend1_reg)) begin
      pend1_reg <= 1'b1;
    end else if (!end0 && fifo_in_ready) begin
      pend1_reg <= 1'b0;
    end
  end

  // buffer feed: first converter first; in differential mode only it
  assign fifo_in_valid = ctrl_reg.dma_en
                         && (end0 || pend1_reg || (end1 && !ctrl_reg.diff));  // R06
  assign fifo_in_data  = end0 ? CONV0_DATA_I : (pend1_reg ? res1_reg : CONV1_DATA_I);

  dsac_fifo #(
    .WIDTH (DSAC_DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .CLK_I       (CLK_I),
    .RSTN_I      (RSTN_I),
    .in_data_i   (fifo_in_data),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .out_data_o  (fifo_out_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (dma_st_reg == DMA_IDLE)
  );

  // transfer engine: one memory write per buffered result
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      dma_st_reg   <= DMA_IDLE;
      MEM_REQ_O    <= 1'b0;
      MEM_WR_O     <= '0;
      addr_ptr_reg <= BASE_RST;
    end else begin
      case (dma_st_reg)
        DMA_IDLE: begin
          if (wr_en && awaddr_reg == OFS_DMABASE) begin
            addr_ptr_reg <= wr_word[15:0];  // new base restarts the walk unless a buffered result is sent this cycle; a base write during DMA_WRITE never reaches the walk
          end
          if (fifo_out_valid) begin
            MEM_WR_O     <= '{ext: ctrl_reg.dma_ext, addr: addr_ptr_reg,
                              data: fifo_out_data};  // R06
            MEM_REQ_O    <= 1'b1;
            addr_ptr_reg <= addr_ptr_reg + ADDR_STEP;
            dma_st_reg   <= DMA_WRITE;
          end
        end
        DMA_WRITE: begin
          if (MEM_ACK_I) begin  // memory stall holds the request
            MEM_REQ_O  <= 1'b0;
            dma_st_reg <= DMA_IDLE;
          end
        end
        default: dma_st_reg <= DMA_IDLE;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_end0;
    busy0_reg && CONV0_DONE_I && !ctrl_reg.shutdown;
  endsequence
  sequence s_hit;
    s_end0 ##0 win_hit;
  endsequence

  property p_sw_start;
    sw0 && ctrl_reg.trig0 == TRIG_SW && !ctrl_reg.shutdown && room && !busy0_reg && !busy1_reg
      |=> CONV0_START_O && busy0_reg;
  endproperty
  a_sw_start: assert property (p_sw_start) else $error("sw start lost");  // R01
  property p_lock;
    lock && CONV0_START_O |-> CONV1_START_O;
  endproperty
  a_lock: assert property (p_lock) else $error("locked starts differ");  // R02
  property p_diff;
    ctrl_reg.diff |=> DIFF_O;
  endproperty
  a_diff: assert property (p_diff) else $error("diff pin not set");  // R03
  property p_done_irq;
    s_end0 ##1 ctrl_reg.done_irq_en |=> CONV_IRQ_O;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done irq missing");  // R04
  property p_capture;
    s_end0 |=> res0_reg == $past(CONV0_DATA_I) && done_reg[0];
  endproperty
  a_capture: assert property (p_capture) else $error("result not captured");  // R05
  property p_mem_hold;
    MEM_REQ_O && !MEM_ACK_I |=> MEM_REQ_O && $stable(MEM_WR_O);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("mem write dropped");  // R06
  property p_win_hit;
    s_hit |=> win_reg;
  endproperty
  a_win_hit: assert property (p_win_hit) else $error("window hit lost");  // R07
  property p_win_miss;
    !win_reg && !(end0 && win_hit) |=> !win_reg;
  endproperty
  a_win_miss: assert property (p_win_miss) else $error("window flag on miss");  // R08
  property p_shdn;
    ctrl_reg.shutdown |=> !CONV0_START_O && !CONV1_START_O && SHDN_O;
  endproperty
  a_shdn: assert property (p_shdn) else $error("start during shutdown");  // R09
  property p_busy;
    busy0_reg ##1 busy0_reg |-> !CONV0_START_O;
  endproperty
  a_busy: assert property (p_busy) else $error("retrigger while busy");  // R11

endmodule : dsac_top
`default_nettype wire

//--- dsac_top_tb.sv
// self-checking bench of the dual converter control
`timescale 1ns/10ps
`default_nettype none
module dsac_top_tb;
  import dsac_pkg::*;
  logic CLK_I, RSTN_I = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic t2 = 0, t3 = 0, ex = 0, ack = 0, d0, d1, st0, st1;
  logic [5:0] aa = 0, ra = 0;
  logic [31:0] wd = 0, rdat;
  logic [15:0] v0, v1;
  logic [1:0] rsp, brsp;
  dsac_mem_wr_t mw, md = '0;
  logic awr, wr_r, bv, arr, rv, req;
  int err_total = 0, checked = 0, s0 = 0, sb = 0, n;
  dsac_top dut_u (.CLK_I(CLK_I), .RSTN_I(RSTN_I), .S_AXI_AWADDR_I(aa), .S_AXI_AWVALID_I(awv),
    .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(4'hf), .S_AXI_WVALID_I(wv),
    .S_AXI_WREADY_O(wr_r), .S_AXI_BRESP_O(brsp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bre),
    .S_AXI_ARADDR_I(ra), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdat),
    .S_AXI_RRESP_O(rsp), .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rre), .TMR2_OVF_I(t2),
    .TMR3_OVF_I(t3), .EXT_START_I(ex), .CONV0_START_O(st0), .CONV1_START_O(st1),
    .CONV0_DONE_I(d0), .CONV1_DONE_I(d1), .CONV0_DATA_I(v0), .CONV1_DATA_I(v1), .DIFF_O(),
    .SHDN_O(), .CONV_IRQ_O(), .WIN_IRQ_O(), .MEM_WR_O(mw), .MEM_REQ_O(req), .MEM_ACK_I(ack));
  dsac_conv_model #(.VAL(16'h1234)) m0_u (.clk_i(CLK_I), .rstn_i(RSTN_I), .start_i(st0),
    .done_o(d0), .data_o(v0));
  dsac_conv_model #(.VAL(16'h5678)) m1_u (.clk_i(CLK_I), .rstn_i(RSTN_I), .start_i(st1),
    .done_o(d1), .data_o(v1));
  initial begin
    CLK_I = 0;
    forever #5 CLK_I = ~CLK_I;
  end
  // memory side acks each request once; start pulses counted
  always @(posedge CLK_I) begin
    ack <= req && !ack;
    if (req && ack) md <= mw;
    if (st0) s0++;
    if (st0 && st1) sb++;
  end
  task summarize;
    $display("mismatches %0d of %0d checks", err_total, checked);
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      $display("unexpected %s exp %h got %h", nm, e, g);
      err_total++;
    end
  endtask : chk
  task wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    aa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK_I);
      if (awv && awr) awv <= 0;
      if (wv && wr_r) wv <= 0;
      if (bv) break;
    end
    bre <= 0;
    if (n == 50) begin err_total++; summarize(); end
  endtask : wr
  task rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    @(posedge CLK_I);
    ra <= a; arv <= 1; rre <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge CLK_I);
      if (arv && arr) arv <= 0;
      if (rv) break;
    end
    rre <= 0;
    if (n == 50) begin err_total++; summarize(); end
    chk(nm, e, rdat & m);
  endtask : rd
  task pulse(input int k);
    if (k == 2) t2 <= 1; else if (k == 3) t3 <= 1; else ex <= 1;
    @(posedge CLK_I);
    t2 <= 0; t3 <= 0; ex <= 0;
    repeat (120) @(posedge CLK_I);
  endtask : pulse
  task t_reset;
    chk("shdn", 1, dut_u.SHDN_O);
    rd(OFS_CTRL, 32'hfff, 32'h001, "ctrl");
    rd(6'h20, 32'hffffffff, 32'h0, "unmapped");
    chk("rresp", 32'h2, rsp);
    wr(6'h20, 32'h0);
    chk("bresp", 32'h2, brsp);
    wr(OFS_CMD, 32'h1);
    chk("start in shutdown", 0, s0);
  endtask : t_reset
  task t_sw;
    wr(OFS_CTRL, 32'h040);
    wr(OFS_CMD, 32'h1);
    repeat (120) @(posedge CLK_I);
    rd(OFS_RES0, 32'hffff, 32'h1234, "res0");
    rd(OFS_STATUS, 32'h1, 32'h1, "done0");
    chk("conv irq", 1, dut_u.CONV_IRQ_O);
    rd(OFS_STATUS, 32'h1, 32'h1, "done0 kept");
    wr(OFS_STATUS, 32'h7);
    rd(OFS_STATUS, 32'h7, 32'h0, "cleared");
  endtask : t_sw
  task t_tmr;
    wr(OFS_CTRL, 32'h100);
    s0 = 0;
    t2 <= 1;
    @(posedge CLK_I);
    t2 <= 0;
    repeat (5) @(posedge CLK_I);
    pulse(2);
    chk("timer starts", 1, s0);
  endtask : t_tmr
  task t_sync;
    wr(OFS_CTRL, 32'h206);
    pulse(3);
    chk("joint start", 1, sb);
    chk("diff", 1, dut_u.DIFF_O);
    wr(OFS_CTRL, 32'h306);
    pulse(4);
    chk("ext joint start", 2, sb);
  endtask : t_sync
  task t_win;
    wr(OFS_WINLO, 32'h1000);
    wr(OFS_WINHI, 32'h2000);
    wr(OFS_STATUS, 32'h7);
    wr(OFS_CTRL, 32'h0a8);
    wr(OFS_CMD, 32'h1);
    repeat (120) @(posedge CLK_I);
    chk("win irq", 1, dut_u.WIN_IRQ_O);
    chk("mem data", 32'h1234, md.data);
    wr(OFS_STATUS, 32'h7);
    wr(OFS_CTRL, 32'h088);
    wr(OFS_CMD, 32'h1);
    repeat (120) @(posedge CLK_I);
    chk("win irq on miss", 0, dut_u.WIN_IRQ_O);
    chk("mem addr", 32'h2, md.addr);
  endtask : t_win
  initial begin
    repeat (10) @(posedge CLK_I);
    RSTN_I <= 1;
    t_reset();
    t_sw();
    t_tmr();
    t_sync();
    t_win();
    summarize();
  end
endmodule : dsac_top_tb
`default_nettype wire
